// file: hdl/oag_pkg.sv
// Package for the operand address generator: modes, targets, layout constants and carriers
package oag_pkg;
	// Addressing modes
	typedef enum logic [2:0] {
		OAG_MODE_REG,
		OAG_MODE_PTR,
		OAG_MODE_IDX,
		OAG_MODE_DIR,
		OAG_MODE_REL,
		OAG_MODE_LIT
	} oag_mode_t;
	// Instruction classes that the mode check distinguishes
	typedef enum logic [2:0] {
		OAG_INSTR_OTHER,
		OAG_INSTR_REG_LOAD,
		OAG_INSTR_PROG_LOAD,
		OAG_INSTR_EXT_LOAD,
		OAG_INSTR_JUMP,
		OAG_INSTR_CALL,
		OAG_INSTR_REL_JUMP
	} oag_instr_t;
	// Where the operand lives
	typedef enum logic [2:0] {
		OAG_TGT_NONE,
		OAG_TGT_REGFILE,
		OAG_TGT_PROG,
		OAG_TGT_EXT,
		OAG_TGT_LITERAL,
		OAG_TGT_PC
	} oag_target_t;
	// Working-register window base and span
	localparam logic [7:0] OAG_WIN_BASE = 8'hc0;
	localparam logic [7:0] OAG_WIN_LAST = 8'hcf;
	localparam int OAG_WIN_SEL_W = 4;
	// Pair pointer must be even; the odd neighbour holds the low byte
	localparam logic [7:0] OAG_PAIR_ODD = 8'h01;
	// Reset value of every output word
	localparam logic [15:0] OAG_ADDR_RST = 16'h0000;
	localparam logic [7:0] OAG_BYTE_RST = 8'h00;
	// Decoded request from the instruction decoder
	typedef struct packed {
		logic valid;
		oag_instr_t instr;
		oag_mode_t mode;
		logic working;
		logic [3:0] wsel;
		logic [7:0] reg_addr;
		logic pair;
		logic ext_mem;
		logic long_off;
		logic [15:0] field;
	} oag_req_t;
	// Values read from the register file for this request
	typedef struct packed {
		logic [7:0] reg_val;
		logic [7:0] pair_hi;
		logic [7:0] pair_lo;
	} oag_rf_t;
	// Result handed to the datapath
	typedef struct packed {
		logic valid;
		logic illegal;
		oag_target_t target;
		logic [15:0] addr;
		logic [7:0] operand;
		logic pc_load;
		logic [15:0] pc_next;
	} oag_res_t;
	// Whole module state
	typedef struct packed {
		oag_res_t res;
		logic [7:0] rd_addr;
	} oag_state_t;
endpackage

// file: hdl/oag_core.sv
// Operand address generator: turns decoded addressing fields into operand and jump addresses
// Function
// RULE1: Six modes; each instruction accepts its own subset
// RULE2: Register mode uses named register's content
// RULE3: Four-bit field selects byte in 16-byte window
// RULE4: Pointer mode uses register content as address
// RULE5: Byte register points regfile; pair points memory
// RULE6: Short offset sign-extended, external memory only
// RULE7: Regfile index: instruction base plus working offset
// RULE8: Memory index: pair base plus instruction offset
// RULE9: Regfile indexed allowed for register load only
// RULE10: Memory loads may index program/external memory
// RULE11: Direct mode takes 16-bit address from instruction
// RULE12: Jump and call direct load PC
// RULE13: Memory loads may use direct 16-bit address
// RULE14: Relative mode adds signed byte to PC
// RULE15: PC already points past current instruction
// RULE16: Relative mode only for relative jump
// RULE17: Literal mode uses operand field directly
// RULE18: Window at C0-CF, reached by working addressing
// RULE19: Pair even address holds most significant byte
// RULE20: Regfile indexed sum wraps modulo 256
`timescale 1ns/1ps
module oag_core #(
	parameter bit EXT_DATA_PRESENT = 1'b1 // External data memory fitted
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	// Decoded instruction and its register reads
	input wire oag_pkg::oag_req_t req,
	input wire oag_pkg::oag_rf_t rf,
	// Address of the instruction after the current one
	input wire logic [15:0] pc_after,
	// Register read address for the register file port
	output logic [7:0] rf_rd_addr,
	// Result
	output oag_pkg::oag_res_t res
);
	oag_pkg::oag_state_t s_q; // Registered state
	oag_pkg::oag_state_t s_d; // Next state
	logic [7:0] rd_addr_d; // Next read address
	logic [7:0] wreg; // Working-register address
	logic [15:0] pair_val; // Pair content
	logic [15:0] offs; // Memory index offset
	logic legal; // Mode allowed for instruction

	// Working-register address: window base plus 4-bit select
	always_comb begin
		wreg = oag_pkg::OAG_WIN_BASE | {4'h0, req.wsel}; // RULE3
	end

	// Read address: working select or plain register, aligned even for pairs
	always_comb begin
		rd_addr_d = req.working ? wreg : req.reg_addr;
		if (req.pair) begin
			rd_addr_d = rd_addr_d & ~oag_pkg::OAG_PAIR_ODD; // RULE19
		end
	end

	// Pair: high byte from even register, low byte from odd neighbour
	always_comb begin
		pair_val = {rf.pair_hi, rf.pair_lo}; // RULE19
		// Short offset is sign-extended, long offset used whole
		offs = req.long_off ? req.field : {{8{req.field[7]}}, req.field[7:0]}; // RULE6
	end

	// Mode legality per instruction class
	always_comb begin
		legal = 1'b0;
		case (req.mode) // RULE1
			oag_pkg::OAG_MODE_REG: begin
				// Window locations only through working addressing
				legal = req.working ||
					!(req.reg_addr >= oag_pkg::OAG_WIN_BASE &&
					req.reg_addr <= oag_pkg::OAG_WIN_LAST); // RULE18
			end
			oag_pkg::OAG_MODE_PTR: begin
				legal = 1'b1;
			end
			oag_pkg::OAG_MODE_IDX: begin
				if (req.ext_mem) begin
					// Memory indexing for program or external loads
					legal = (req.instr == oag_pkg::OAG_INSTR_PROG_LOAD) ||
						(req.instr == oag_pkg::OAG_INSTR_EXT_LOAD && EXT_DATA_PRESENT); // RULE10
				end else begin
					// Register file indexing: register load, short byte base only
					legal = (req.instr == oag_pkg::OAG_INSTR_REG_LOAD) && !req.long_off; // RULE9
				end
			end
			oag_pkg::OAG_MODE_DIR: begin
				legal = (req.instr == oag_pkg::OAG_INSTR_JUMP) ||
					(req.instr == oag_pkg::OAG_INSTR_CALL) ||
					(req.instr == oag_pkg::OAG_INSTR_PROG_LOAD) ||
					(req.instr == oag_pkg::OAG_INSTR_EXT_LOAD && EXT_DATA_PRESENT); // RULE13
			end
			oag_pkg::OAG_MODE_REL: begin
				legal = (req.instr == oag_pkg::OAG_INSTR_REL_JUMP); // RULE16
			end
			oag_pkg::OAG_MODE_LIT: begin
				legal = 1'b1;
			end
			default: begin
				legal = 1'b0;
			end
		endcase
	end

	// Result formation
	always_comb begin
		s_d = s_q;
		s_d.res.valid = 1'b0;
		s_d.res.pc_load = 1'b0;
		s_d.rd_addr = rd_addr_d; // Read address follows every enabled cycle
		if (req.valid) begin
			s_d.res.valid = 1'b1;
			s_d.res.illegal = !legal;
			s_d.res.target = oag_pkg::OAG_TGT_NONE;
			s_d.res.addr = oag_pkg::OAG_ADDR_RST;
			s_d.res.operand = oag_pkg::OAG_BYTE_RST;
			s_d.res.pc_next = pc_after;
			if (legal) begin
				case (req.mode)
					oag_pkg::OAG_MODE_REG: begin
						// Operand is the named register's content
						s_d.res.target = oag_pkg::OAG_TGT_REGFILE;
						s_d.res.addr = {8'h00, rd_addr_d};
						s_d.res.operand = rf.reg_val; // RULE2
					end
					oag_pkg::OAG_MODE_PTR: begin
						if (req.pair) begin
							// Pair points into program or external memory
							s_d.res.target = (req.instr == oag_pkg::OAG_INSTR_EXT_LOAD) ?
								oag_pkg::OAG_TGT_EXT : oag_pkg::OAG_TGT_PROG; // RULE4
							s_d.res.addr = pair_val; // RULE5
						end else begin
							// Byte register points to another register
							s_d.res.target = oag_pkg::OAG_TGT_REGFILE;
							s_d.res.addr = {8'h00, rf.reg_val}; // RULE5
						end
					end
					oag_pkg::OAG_MODE_IDX: begin
						if (req.ext_mem) begin
							s_d.res.target = (req.instr == oag_pkg::OAG_INSTR_EXT_LOAD) ?
								oag_pkg::OAG_TGT_EXT : oag_pkg::OAG_TGT_PROG;
							s_d.res.addr = 16'(pair_val + offs); // RULE8
						end else begin
							// Carry out of bit 7 is dropped on purpose
							s_d.res.target = oag_pkg::OAG_TGT_REGFILE;
							s_d.res.addr = {8'h00, 8'(req.field[7:0] + rf.reg_val)}; // RULE7 RULE20
						end
					end
					oag_pkg::OAG_MODE_DIR: begin
						s_d.res.addr = req.field; // RULE11
						if (req.instr == oag_pkg::OAG_INSTR_JUMP ||
							req.instr == oag_pkg::OAG_INSTR_CALL) begin
							s_d.res.target = oag_pkg::OAG_TGT_PC;
							s_d.res.pc_load = 1'b1;
							s_d.res.pc_next = req.field; // RULE12
						end else begin
							s_d.res.target = (req.instr == oag_pkg::OAG_INSTR_EXT_LOAD) ?
								oag_pkg::OAG_TGT_EXT : oag_pkg::OAG_TGT_PROG; // RULE13
						end
					end
					oag_pkg::OAG_MODE_REL: begin
						// Base is already the following instruction's address
						s_d.res.target = oag_pkg::OAG_TGT_PC;
						s_d.res.pc_load = 1'b1;
						s_d.res.pc_next = 16'(pc_after + {{8{req.field[7]}}, req.field[7:0]}); // RULE14 RULE15
						s_d.res.addr = s_d.res.pc_next;
					end
					oag_pkg::OAG_MODE_LIT: begin
						// Constant straight from the instruction, no read
						s_d.res.target = oag_pkg::OAG_TGT_LITERAL;
						s_d.res.operand = req.field[7:0]; // RULE17
					end
					default: begin
						s_d.res.target = oag_pkg::OAG_TGT_NONE;
					end
				endcase
			end
		end
	end

	// State register, frozen while the clock enable is low
	// The read address lives in the same word, so a stall freezes both together
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from the state flip-flops
	assign res = s_q.res;
	assign rf_rd_addr = s_q.rd_addr;

	AST_REL_ONLY_RJUMP: assert property (@(posedge clk_sys) disable iff (rst) // RULE16
		(clk_en && req.valid && req.mode == oag_pkg::OAG_MODE_REL &&
		req.instr != oag_pkg::OAG_INSTR_REL_JUMP) |=> (res.illegal && !res.pc_load))
		else $error("relative mode accepted for wrong instruction");
	AST_REL_TARGET: assert property (@(posedge clk_sys) disable iff (rst) // RULE14
		(clk_en && req.valid && req.mode == oag_pkg::OAG_MODE_REL &&
		req.instr == oag_pkg::OAG_INSTR_REL_JUMP) |=>
		(res.pc_next == 16'($past(pc_after) + {{8{$past(req.field[7])}}, $past(req.field[7:0])})))
		else $error("relative target wrong");
	AST_JUMP_LOAD: assert property (@(posedge clk_sys) disable iff (rst) // RULE12
		(clk_en && req.valid && req.mode == oag_pkg::OAG_MODE_DIR &&
		req.instr == oag_pkg::OAG_INSTR_JUMP) |=> (res.pc_load && res.pc_next == $past(req.field)))
		else $error("direct jump did not load pc");
	AST_IDX_WRAP: assert property (@(posedge clk_sys) disable iff (rst) // RULE20
		(clk_en && req.valid && req.mode == oag_pkg::OAG_MODE_IDX && !req.ext_mem &&
		req.instr == oag_pkg::OAG_INSTR_REG_LOAD && !req.long_off) |=>
		(res.addr == {8'h00, 8'($past(req.field[7:0]) + $past(rf.reg_val))}))
		else $error("register index sum wrong");
	AST_IDX_REG_ONLY_LOAD: assert property (@(posedge clk_sys) disable iff (rst) // RULE9
		(clk_en && req.valid && req.mode == oag_pkg::OAG_MODE_IDX && !req.ext_mem &&
		req.instr != oag_pkg::OAG_INSTR_REG_LOAD) |=> res.illegal)
		else $error("register indexing accepted for wrong instruction");
	AST_SHORT_SIGN: assert property (@(posedge clk_sys) disable iff (rst) // RULE6
		(clk_en && req.valid && req.mode == oag_pkg::OAG_MODE_IDX && req.ext_mem &&
		req.instr == oag_pkg::OAG_INSTR_PROG_LOAD && !req.long_off) |=>
		(res.addr == 16'({$past(rf.pair_hi), $past(rf.pair_lo)} +
		{{8{$past(req.field[7])}}, $past(req.field[7:0])})))
		else $error("short offset not sign extended");
	AST_LIT_OPERAND: assert property (@(posedge clk_sys) disable iff (rst) // RULE17
		(clk_en && req.valid && req.mode == oag_pkg::OAG_MODE_LIT) |=>
		(res.target == oag_pkg::OAG_TGT_LITERAL && res.operand == $past(req.field[7:0])))
		else $error("literal operand wrong");
	AST_WIN_ADDR: assert property (@(posedge clk_sys) disable iff (rst) // RULE3
		(clk_en && req.working && !req.pair) |=> (rf_rd_addr == {4'hc, $past(req.wsel)}))
		else $error("working register address wrong");
	AST_WIN_DIRECT: assert property (@(posedge clk_sys) disable iff (rst) // RULE18
		(clk_en && req.valid && req.mode == oag_pkg::OAG_MODE_REG && !req.working &&
		req.reg_addr[7:4] == 4'hc) |=> res.illegal)
		else $error("window reached without working addressing");

	// Checks below look at the answer on the next clock edge after an enabled request, whether or not that edge is enabled
	// Antecedents include clk_en, so a stall never shifts the edge being judged
	// Every enabled request answers on the next edge
	AST_VALID_ANSWER: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
		(clk_en && req.valid) |=> res.valid)
		else $error("request not answered");
	// No answer appears without a request
	AST_VALID_IDLE: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
		(clk_en && !req.valid) |=> !res.valid)
		else $error("answer without request");
	// A refused mode leaves only the following address behind
	AST_REFUSED_CLEAN: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
		(clk_en && req.valid && req.mode == oag_pkg::OAG_MODE_DIR &&
		req.instr == oag_pkg::OAG_INSTR_OTHER) |=>
		(res.illegal && res.target == oag_pkg::OAG_TGT_NONE && !res.pc_load &&
		res.addr == oag_pkg::OAG_ADDR_RST && res.pc_next == $past(pc_after)))
		else $error("refused request left a result behind");
	// Only counter loads name the counter as target
	AST_PC_TARGET: assert property (@(posedge clk_sys) disable iff (rst) // RULE12
		(clk_en && req.valid) |=> (res.pc_load == (res.target == oag_pkg::OAG_TGT_PC)))
		else $error("counter load and target disagree");
	// Working register operand is the selected window byte
	AST_REG_OPERAND: assert property (@(posedge clk_sys) disable iff (rst) // RULE2
		(clk_en && req.valid && req.mode == oag_pkg::OAG_MODE_REG && req.working) |=>
		(!res.illegal && res.operand == $past(rf.reg_val)))
		else $error("register operand wrong");
	// Byte pointer stays inside the register file
	AST_PTR_BYTE: assert property (@(posedge clk_sys) disable iff (rst) // RULE5
		(clk_en && req.valid && req.mode == oag_pkg::OAG_MODE_PTR && !req.pair) |=>
		(res.target == oag_pkg::OAG_TGT_REGFILE &&
		res.addr == {8'h00, $past(rf.reg_val)}))
		else $error("byte pointer address wrong");
	// Pair pointer goes to memory, never back into the register file
	AST_PTR_PAIR: assert property (@(posedge clk_sys) disable iff (rst) // RULE4
		(clk_en && req.valid && req.mode == oag_pkg::OAG_MODE_PTR && req.pair) |=>
		(res.target != oag_pkg::OAG_TGT_REGFILE &&
		res.addr == {$past(rf.pair_hi), $past(rf.pair_lo)}))
		else $error("pair pointer address wrong");
	// A pair is always fetched from its even register
	AST_PAIR_EVEN: assert property (@(posedge clk_sys) disable iff (rst) // RULE19
		(clk_en && req.pair) |=> !rf_rd_addr[0])
		else $error("pair read from an odd register");
	// Register file index lands in the register file
	AST_IDX_RF_TARGET: assert property (@(posedge clk_sys) disable iff (rst) // RULE7
		(clk_en && req.valid && req.mode == oag_pkg::OAG_MODE_IDX && !req.ext_mem &&
		req.instr == oag_pkg::OAG_INSTR_REG_LOAD && !req.long_off) |=>
		(!res.illegal && res.target == oag_pkg::OAG_TGT_REGFILE))
		else $error("register index left the register file");
	// Long offsets are added whole, with no sign extension
	AST_IDX_LONG: assert property (@(posedge clk_sys) disable iff (rst) // RULE8
		(clk_en && req.valid && req.mode == oag_pkg::OAG_MODE_IDX && req.ext_mem &&
		req.long_off && req.instr == oag_pkg::OAG_INSTR_EXT_LOAD && EXT_DATA_PRESENT) |=>
		(res.addr == 16'({$past(rf.pair_hi), $past(rf.pair_lo)} + $past(req.field))))
		else $error("long offset address wrong");
	// Memory loads use the direct address as it stands and leave the counter alone
	AST_DIR_LOAD: assert property (@(posedge clk_sys) disable iff (rst) // RULE13
		(clk_en && req.valid && req.mode == oag_pkg::OAG_MODE_DIR &&
		(req.instr == oag_pkg::OAG_INSTR_PROG_LOAD ||
		(req.instr == oag_pkg::OAG_INSTR_EXT_LOAD && EXT_DATA_PRESENT))) |=>
		(!res.illegal && !res.pc_load && res.addr == $past(req.field)))
		else $error("direct load address wrong");
	// A call loads the counter just as a jump does
	AST_CALL_LOAD: assert property (@(posedge clk_sys) disable iff (rst) // RULE12
		(clk_en && req.valid && req.mode == oag_pkg::OAG_MODE_DIR &&
		req.instr == oag_pkg::OAG_INSTR_CALL) |=>
		(res.pc_load && res.pc_next == $past(req.field)))
		else $error("direct call did not load pc");
	// A relative jump always loads the counter
	AST_REL_LOAD: assert property (@(posedge clk_sys) disable iff (rst) // RULE14
		(clk_en && req.valid && req.mode == oag_pkg::OAG_MODE_REL &&
		req.instr == oag_pkg::OAG_INSTR_REL_JUMP) |=> (res.pc_load && !res.illegal))
		else $error("relative jump did not load pc");
	// A literal never jumps and is never refused
	AST_LIT_NO_LOAD: assert property (@(posedge clk_sys) disable iff (rst) // RULE17
		(clk_en && req.valid && req.mode == oag_pkg::OAG_MODE_LIT) |=>
		(!res.pc_load && !res.illegal))
		else $error("literal request misread");
endmodule

// file: verif/oag_rf_model.sv
// Behavioural register file that answers the generator's operand reads
`timescale 1ns/1ps
module oag_rf_model (
	// Request seen by the generator
	input wire oag_pkg::oag_req_t req,
	// Same-cycle read data
	output oag_pkg::oag_rf_t rf
);
	logic [7:0] sel; // Register that the request names

	// Contents are a fixed scramble of the address so every location reads differently
	always_comb begin
		sel = req.working ? {4'hc, req.wsel} : req.reg_addr;
		rf.reg_val = sel ^ 8'h5a;
		// Pairs always read from the even register, even if an odd one is named
		rf.pair_hi = {sel[7:1], 1'b0} ^ 8'h5a;
		rf.pair_lo = {sel[7:1], 1'b1} ^ 8'h5a;
	end
endmodule

// file: verif/operand_address_generator_tb.sv
// Self-checking bench for the operand address generator
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; $display("mismatch t=%0t got=%0h exp=%0h", $time, a, b); end end
module operand_address_generator_tb;
	logic clk_sys; // Core clock
	logic rst; // Async reset
	logic clk_en; // Stall control
	oag_pkg::oag_req_t req; // Decoded request
	oag_pkg::oag_rf_t rf; // Register reads
	logic [15:0] pc_after; // Following instruction address
	logic [7:0] rf_rd_addr; // Read address out
	oag_pkg::oag_res_t res; // Result
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;

	oag_core i_oag_core (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .req(req), .rf(rf),
		.pc_after(pc_after), .rf_rd_addr(rf_rd_addr), .res(res));
	oag_rf_model i_oag_rf_model (.req(req), .rf(rf));

	// 20 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Hang guard: the whole run needs well under a hundred cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			wrap_up();
		end
	end

	// Scrambled contents of the register file model
	function automatic logic [7:0] rv(input logic [7:0] a);
		return a ^ 8'h5a;
	endfunction

	// Present one request for a single cycle; fl is {pair, ext_mem, long_off}
	task automatic go(input oag_pkg::oag_instr_t ins, input oag_pkg::oag_mode_t md,
		input logic w, input logic [7:0] adr, input logic [2:0] fl, input logic [15:0] f);
		req.valid = 1'b1;
		req.instr = ins;
		req.mode = md;
		req.working = w;
		req.wsel = adr[3:0];
		req.reg_addr = adr;
		{req.pair, req.ext_mem, req.long_off} = fl;
		req.field = f;
		@(posedge clk_sys);
		#1;
		req.valid = 1'b0;
		`CHK(res.valid, 1'b1)
	endtask

	// Judge the answer, then see that the valid pulse lasts one cycle only
	task automatic exp(input logic ill, input oag_pkg::oag_target_t tgt, input logic [15:0] a,
		input logic pcl);
		`CHK(res.illegal, ill)
		`CHK(res.target, tgt)
		`CHK(res.addr, a)
		`CHK(res.pc_load, pcl)
		if (ill) `CHK(res.pc_next, pc_after)
		@(posedge clk_sys);
		#1;
		`CHK(res.valid, 1'b0)
	endtask

	// Register mode, working window and the forbidden direct window access
	task automatic t_reg;
		go(oag_pkg::OAG_INSTR_OTHER, oag_pkg::OAG_MODE_REG, 1'b1, 8'h0f, 3'b000, 16'h0);
		`CHK(res.operand, rv(8'hcf))
		`CHK(rf_rd_addr, 8'hcf)
		exp(1'b0, oag_pkg::OAG_TGT_REGFILE, 16'h00cf, 1'b0);
		go(oag_pkg::OAG_INSTR_OTHER, oag_pkg::OAG_MODE_REG, 1'b0, 8'h40, 3'b000, 16'h0);
		`CHK(res.operand, rv(8'h40))
		exp(1'b0, oag_pkg::OAG_TGT_REGFILE, 16'h0040, 1'b0);
		go(oag_pkg::OAG_INSTR_REG_LOAD, oag_pkg::OAG_MODE_REG, 1'b0, 8'hc2, 3'b000, 16'h0);
		exp(1'b1, oag_pkg::OAG_TGT_NONE, 16'h0000, 1'b0);
	endtask

	// Byte and pair pointers; an odd pair name still reads the even register first
	task automatic t_ptr;
		go(oag_pkg::OAG_INSTR_OTHER, oag_pkg::OAG_MODE_PTR, 1'b0, 8'h20, 3'b000, 16'h0);
		exp(1'b0, oag_pkg::OAG_TGT_REGFILE, {8'h00, rv(8'h20)}, 1'b0);
		go(oag_pkg::OAG_INSTR_PROG_LOAD, oag_pkg::OAG_MODE_PTR, 1'b0, 8'h31, 3'b100, 16'h0);
		`CHK(rf_rd_addr, 8'h30)
		exp(1'b0, oag_pkg::OAG_TGT_PROG, 16'h6a6b, 1'b0);
		go(oag_pkg::OAG_INSTR_EXT_LOAD, oag_pkg::OAG_MODE_PTR, 1'b0, 8'h30, 3'b100, 16'h0);
		exp(1'b0, oag_pkg::OAG_TGT_EXT, 16'h6a6b, 1'b0);
	endtask

	// Indexed: register file wrap, wrong instruction, short and long memory offsets
	task automatic t_idx;
		go(oag_pkg::OAG_INSTR_REG_LOAD, oag_pkg::OAG_MODE_IDX, 1'b1, 8'h03, 3'b000, 16'h00f0);
		exp(1'b0, oag_pkg::OAG_TGT_REGFILE, 16'h0089, 1'b0);
		go(oag_pkg::OAG_INSTR_OTHER, oag_pkg::OAG_MODE_IDX, 1'b1, 8'h03, 3'b000, 16'h00f0);
		exp(1'b1, oag_pkg::OAG_TGT_NONE, 16'h0000, 1'b0);
		go(oag_pkg::OAG_INSTR_PROG_LOAD, oag_pkg::OAG_MODE_IDX, 1'b0, 8'h30, 3'b110, 16'h0080);
		exp(1'b0, oag_pkg::OAG_TGT_PROG, 16'h69eb, 1'b0);
		go(oag_pkg::OAG_INSTR_EXT_LOAD, oag_pkg::OAG_MODE_IDX, 1'b0, 8'h30, 3'b111, 16'h1000);
		exp(1'b0, oag_pkg::OAG_TGT_EXT, 16'h7a6b, 1'b0);
	endtask

	// Direct: jump and call load the counter, loads address memory, others refused
	task automatic t_dir;
		go(oag_pkg::OAG_INSTR_JUMP, oag_pkg::OAG_MODE_DIR, 1'b0, 8'h00, 3'b000, 16'hbeef);
		`CHK(res.pc_next, 16'hbeef)
		exp(1'b0, oag_pkg::OAG_TGT_PC, 16'hbeef, 1'b1);
		go(oag_pkg::OAG_INSTR_CALL, oag_pkg::OAG_MODE_DIR, 1'b0, 8'h00, 3'b000, 16'h8001);
		`CHK(res.pc_next, 16'h8001)
		exp(1'b0, oag_pkg::OAG_TGT_PC, 16'h8001, 1'b1);
		go(oag_pkg::OAG_INSTR_EXT_LOAD, oag_pkg::OAG_MODE_DIR, 1'b0, 8'h00, 3'b000, 16'hf00d);
		exp(1'b0, oag_pkg::OAG_TGT_EXT, 16'hf00d, 1'b0);
		go(oag_pkg::OAG_INSTR_OTHER, oag_pkg::OAG_MODE_DIR, 1'b0, 8'h00, 3'b000, 16'hf00d);
		exp(1'b1, oag_pkg::OAG_TGT_NONE, 16'h0000, 1'b0);
	endtask

	// Relative: both ends of the displacement range, and a refused non-relative jump
	task automatic t_rel;
		go(oag_pkg::OAG_INSTR_REL_JUMP, oag_pkg::OAG_MODE_REL, 1'b0, 8'h00, 3'b000, 16'h0080);
		`CHK(res.pc_next, 16'h11b4)
		exp(1'b0, oag_pkg::OAG_TGT_PC, 16'h11b4, 1'b1);
		go(oag_pkg::OAG_INSTR_REL_JUMP, oag_pkg::OAG_MODE_REL, 1'b0, 8'h00, 3'b000, 16'hff7f);
		`CHK(res.pc_next, 16'h12b3)
		exp(1'b0, oag_pkg::OAG_TGT_PC, 16'h12b3, 1'b1);
		go(oag_pkg::OAG_INSTR_JUMP, oag_pkg::OAG_MODE_REL, 1'b0, 8'h00, 3'b000, 16'h0010);
		exp(1'b1, oag_pkg::OAG_TGT_NONE, 16'h0000, 1'b0);
	endtask

	// Literal operand, with a stall cycle that must not answer early
	task automatic t_lit;
		clk_en = 1'b0;
		req.valid = 1'b1;
		req.instr = oag_pkg::OAG_INSTR_OTHER;
		req.mode = oag_pkg::OAG_MODE_LIT;
		req.field = 16'h5542;
		@(posedge clk_sys);
		#1;
		`CHK(res.valid, 1'b0)
		clk_en = 1'b1;
		@(posedge clk_sys);
		#1;
		req.valid = 1'b0;
		`CHK(res.valid, 1'b1)
		`CHK(res.operand, 8'h42)
		`CHK(res.target, oag_pkg::OAG_TGT_LITERAL)
		`CHK(res.pc_load, 1'b0)
		@(posedge clk_sys);
		#1;
		`CHK(res.valid, 1'b0)
	endtask

	// Reset in mid-run clears a standing answer; the next request is taken at once
	task automatic t_rst;
		go(oag_pkg::OAG_INSTR_JUMP, oag_pkg::OAG_MODE_DIR, 1'b0, 8'h55, 3'b000, 16'h4321);
		rst = 1'b1;
		#1;
		`CHK(res.pc_load, 1'b0)
		`CHK(res.pc_next, 16'h0000)
		`CHK(rf_rd_addr, 8'h00)
		@(posedge clk_sys);
		#1;
		rst = 1'b0;
		go(oag_pkg::OAG_INSTR_OTHER, oag_pkg::OAG_MODE_LIT, 1'b0, 8'h55, 3'b000, 16'h0077);
		`CHK(res.operand, 8'h77)
		exp(1'b0, oag_pkg::OAG_TGT_LITERAL, 16'h0000, 1'b0);
	endtask

	// Counts, verdict and end of run
	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		rst = 1'b1;
		clk_en = 1'b1;
		req = '0;
		pc_after = 16'h1234;
		repeat (4) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		`CHK(res.valid, 1'b0)
		t_reg();
		t_ptr();
		t_idx();
		t_dir();
		t_rel();
		t_lit();
		t_rst();
		wrap_up();
	end
endmodule
